// [include/adc_pp_pkg.sv]
// constants shared by the converter post-processing and interrupt logic
`default_nettype none
package adc_pp_pkg;
    localparam int RAW_W     = 16;
    localparam int RES_W     = 17;
    localparam int NUM_PPB   = 2;
    localparam int NUM_LINES = 4;
    localparam int SLOT_W    = 4;
    localparam int TRIM_W    = 16;
    localparam int TRIM_AW   = 4;
    localparam int NUM_TRIMS = 10;
    localparam int PID_W     = 32;
    localparam int QUALIFICATION_FIELD_W    = 2;
    localparam int DEV_W     = 8;

    // trim store addresses: reference, six linearity words, offset, oscillator, output stage
    localparam logic [TRIM_AW-1:0] TRIM_REF_ADDR   = 4'h0;
    localparam logic [TRIM_AW-1:0] TRIM_LIN_ADDR   = 4'h1;
    localparam logic [TRIM_AW-1:0] TRIM_OFF_ADDR   = 4'h7;
    localparam logic [TRIM_AW-1:0] TRIM_OSC_ADDR   = 4'h8;
    localparam logic [TRIM_AW-1:0] TRIM_OUT_ADDR   = 4'h9;
    localparam logic [TRIM_AW-1:0] TRIM_COUNT      = 4'hA;
    localparam logic [TRIM_W-1:0]  TRIM_RST        = 16'h0000;

    // part identification low word layout
    localparam int                 PID_QUALIFICATION_FIELD_LSB    = 6;
    localparam int                 PID_DEV_LSB     = 8;
    localparam logic [QUALIFICATION_FIELD_W-1:0]  QUALIFICATION_FIELD_PROTOTYPE  = 2'h0;
    localparam logic [PID_W-1:0]   PID_RST         = 32'h00000000;

    localparam logic [RES_W-1:0]   RES_RST         = 17'h00000;
endpackage
`default_nettype wire

// [include/trim_port_if.sv]
// write and read port between the control logic and the trim store
`default_nettype none
interface trim_port_if;
    logic                              we;
    logic [adc_pp_pkg::TRIM_AW-1:0]    waddr;
    logic [adc_pp_pkg::TRIM_W-1:0]     wdata;
    logic [adc_pp_pkg::TRIM_AW-1:0]    raddr;
    logic [adc_pp_pkg::TRIM_W-1:0]     rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [hdl/trim_store.sv]
// trim word store, zero after reset as on an unprogrammed part, registered read
`default_nettype none
module trim_store
(
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rstn,
    // access port
    trim_port_if.store port
);
    logic [adc_pp_pkg::TRIM_W-1:0] mem_q [adc_pp_pkg::NUM_TRIMS];
    logic [adc_pp_pkg::TRIM_W-1:0] mem_d [adc_pp_pkg::NUM_TRIMS];
    logic [adc_pp_pkg::TRIM_W-1:0] rdata_q;
    logic [adc_pp_pkg::TRIM_W-1:0] rdata_d;
    logic                          written_q;
    logic                          written_d;

    always_comb
    begin
        mem_d     = mem_q;
        written_d = written_q | port.we;
        if (port.we && (port.waddr < adc_pp_pkg::TRIM_COUNT))
        begin
            mem_d[port.waddr] = port.wdata;
        end
        // out-of-range reads answer zero rather than aliasing
        rdata_d = (port.raddr < adc_pp_pkg::TRIM_COUNT) ? mem_q[port.raddr]
                                                         : adc_pp_pkg::TRIM_RST;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < adc_pp_pkg::NUM_TRIMS; i++)
            begin
                mem_q[i] <= adc_pp_pkg::TRIM_RST;
            end
            rdata_q   <= adc_pp_pkg::TRIM_RST;
            written_q <= 1'b0;
        end
        else
        begin
            mem_q     <= mem_d;
            rdata_q   <= rdata_d;
            written_q <= written_d;
        end
    end

    assign port.rdata = rdata_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    chk_trim_unprogrammed: assert property (!written_q |=> port.rdata == 16'h0000)
        else $error("untrimmed word read non-zero");
    chk_trim_write_back: assert property (
        (port.we && port.waddr < adc_pp_pkg::TRIM_COUNT) ##1
        (!port.we && port.raddr == $past(port.waddr))
        |=> port.rdata == $past(port.wdata, 2))
        else $error("trim word did not read back");
    cov_trim_write: cover property (port.we && port.waddr == adc_pp_pkg::TRIM_REF_ADDR);
endmodule
`default_nettype wire

// [hdl/adc_pp_top.sv]
// post-processing blocks, conversion interrupt flags, part ident and trims
`default_nettype none
module adc_pp_top
#(
    parameter logic [adc_pp_pkg::QUALIFICATION_FIELD_W-1:0] P_QUALIFICATION_FIELD        = adc_pp_pkg::QUALIFICATION_FIELD_PROTOTYPE,
    // device code value is arbitrary
    parameter logic [adc_pp_pkg::DEV_W-1:0]  P_DEVICE_CODE = 8'h5A
)
(
    // clock and reset
    input  wire logic                                          I_CLK,
    input  wire logic                                          I_RSTN,
    // converter result
    input  wire logic                                          I_CONV_DONE,
    input  wire logic [adc_pp_pkg::SLOT_W-1:0]                 I_CONV_SLOT,
    input  wire logic [adc_pp_pkg::RAW_W-1:0]                  I_RAW_RESULT,
    // post-processing configuration
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0][3:0]           I_PPB_SLOT_SEL,
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0][15:0]          I_PPB_OFFSET,
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0][15:0]          I_PPB_HIGH_LIMIT,
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0][15:0]          I_PPB_LOW_LIMIT,
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0]                I_PPB_HIGH_EN,
    input  wire logic [adc_pp_pkg::NUM_PPB-1:0]                I_PPB_LOW_EN,
    // post-processing results
    output logic      [adc_pp_pkg::NUM_PPB-1:0][16:0]          O_PPB_RESULT,
    output logic      [adc_pp_pkg::NUM_PPB-1:0]                O_PPB_VALID,
    output logic      [adc_pp_pkg::NUM_PPB-1:0]                O_PPB_ZERO_CROSS,
    output logic      [adc_pp_pkg::NUM_PPB-1:0]                O_PPB_HIGH_TRIP,
    output logic      [adc_pp_pkg::NUM_PPB-1:0]                O_PPB_LOW_TRIP,
    output logic      [adc_pp_pkg::NUM_PPB-1:0]                O_PPB_LIMIT_UNRELIABLE,
    // conversion interrupts
    input  wire logic [adc_pp_pkg::NUM_LINES-1:0][3:0]         I_INT_SLOT_SEL,
    input  wire logic [adc_pp_pkg::NUM_LINES-1:0]              I_INT_CONT,
    input  wire logic [adc_pp_pkg::NUM_LINES-1:0]              I_INT_FLAG_CLR,
    input  wire logic [adc_pp_pkg::NUM_LINES-1:0]              I_INT_OVF_CLR,
    output logic      [adc_pp_pkg::NUM_LINES-1:0]              O_INT_FLAG,
    output logic      [adc_pp_pkg::NUM_LINES-1:0]              O_INT_OVF,
    output logic      [adc_pp_pkg::NUM_LINES-1:0]              O_INT_PULSE,
    // identification
    output logic      [adc_pp_pkg::PID_W-1:0]                  O_PART_IDENT_LOW,
    // trims
    input  wire logic                                          I_TRIM_WE,
    input  wire logic [adc_pp_pkg::TRIM_AW-1:0]                I_TRIM_WADDR,
    input  wire logic [adc_pp_pkg::TRIM_W-1:0]                 I_TRIM_WDATA,
    input  wire logic [adc_pp_pkg::TRIM_AW-1:0]                I_TRIM_RADDR,
    output logic      [adc_pp_pkg::TRIM_W-1:0]                 O_TRIM_RDATA
);
    localparam int NP = adc_pp_pkg::NUM_PPB;
    localparam int NL = adc_pp_pkg::NUM_LINES;

    function automatic logic slot_hit(input logic done, input logic [3:0] slot,
                                      input logic [3:0] sel);
        slot_hit = done && (slot == sel);
    endfunction

    // post-processing state
    logic [NP-1:0][16:0] res_q;
    logic [NP-1:0][16:0] res_d;
    logic [NP-1:0]       vld_q;
    logic [NP-1:0]       vld_d;
    logic [NP-1:0]       zc_q;
    logic [NP-1:0]       zc_d;
    logic [NP-1:0]       hi_q;
    logic [NP-1:0]       hi_d;
    logic [NP-1:0]       lo_q;
    logic [NP-1:0]       lo_d;
    logic [NP-1:0]       unrel_q;
    logic [NP-1:0]       unrel_d;
    logic [NP-1:0]       has_prev_q;
    logic [NP-1:0]       has_prev_d;
    logic [NP-1:0]       hit;
    logic [16:0]         diff;

    always_comb
    begin
        res_d      = res_q;
        has_prev_d = has_prev_q;
        zc_d       = '0;
        hi_d       = '0;
        lo_d       = '0;
        diff       = adc_pp_pkg::RES_RST;
        for (int p = 0; p < NP; p++)
        begin
            hit[p]     = slot_hit(I_CONV_DONE, I_CONV_SLOT, I_PPB_SLOT_SEL[p]);
            vld_d[p]   = hit[p];
            // limit results degrade whenever offset and compare are used together
            unrel_d[p] = (I_PPB_HIGH_EN[p] | I_PPB_LOW_EN[p])
                         && (I_PPB_OFFSET[p] != 16'h0000);
            if (hit[p])
            begin
                diff     = {1'b0, I_RAW_RESULT} - {1'b0, I_PPB_OFFSET[p]};
                res_d[p] = diff;
                has_prev_d[p] = 1'b1;
                zc_d[p]  = has_prev_q[p] && (diff[16] != res_q[p][16]);
                // the compare ignores the sign bit, matching the silicon flaw
                hi_d[p]  = I_PPB_HIGH_EN[p] && (diff[15:0] > I_PPB_HIGH_LIMIT[p]);
                lo_d[p]  = I_PPB_LOW_EN[p] && (diff[15:0] < I_PPB_LOW_LIMIT[p]);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            res_q      <= '0;
            vld_q      <= '0;
            zc_q       <= '0;
            hi_q       <= '0;
            lo_q       <= '0;
            unrel_q    <= '0;
            has_prev_q <= '0;
        end
        else
        begin
            res_q      <= res_d;
            vld_q      <= vld_d;
            zc_q       <= zc_d;
            hi_q       <= hi_d;
            lo_q       <= lo_d;
            unrel_q    <= unrel_d;
            has_prev_q <= has_prev_d;
        end
    end

    assign O_PPB_RESULT           = res_q;
    assign O_PPB_VALID            = vld_q;
    assign O_PPB_ZERO_CROSS       = zc_q;
    assign O_PPB_HIGH_TRIP        = hi_q;
    assign O_PPB_LOW_TRIP         = lo_q;
    assign O_PPB_LIMIT_UNRELIABLE = unrel_q;

    // interrupt state
    logic [NL-1:0] ev;
    logic [NL-1:0] flag_q;
    logic [NL-1:0] flag_d;
    logic [NL-1:0] ovf_q;
    logic [NL-1:0] ovf_d;
    logic [NL-1:0] pulse_q;
    logic [NL-1:0] pulse_d;

    always_comb
    begin
        for (int n = 0; n < NL; n++)
        begin
            ev[n]      = slot_hit(I_CONV_DONE, I_CONV_SLOT, I_INT_SLOT_SEL[n]);
            // a new event wins over a clear in the same cycle
            flag_d[n]  = (flag_q[n] & ~I_INT_FLAG_CLR[n]) | ev[n];
            pulse_d[n] = ev[n] && (I_INT_CONT[n] || !flag_q[n]);
            ovf_d[n]   = (ovf_q[n] & ~I_INT_OVF_CLR[n]) | (ev[n] & flag_q[n]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            flag_q  <= '0;
            ovf_q   <= '0;
            pulse_q <= '0;
        end
        else
        begin
            flag_q  <= flag_d;
            ovf_q   <= ovf_d;
            pulse_q <= pulse_d;
        end
    end

    assign O_INT_FLAG  = flag_q;
    assign O_INT_OVF   = ovf_q;
    assign O_INT_PULSE = pulse_q;

    // identification word, zero in reset, loaded on the first edge after reset and constant from then on
    logic [adc_pp_pkg::PID_W-1:0] pid_q;
    logic [adc_pp_pkg::PID_W-1:0] pid_d;

    always_comb
    begin
        pid_d = adc_pp_pkg::PID_RST;
        pid_d[adc_pp_pkg::PID_QUALIFICATION_FIELD_LSB +: adc_pp_pkg::QUALIFICATION_FIELD_W] = P_QUALIFICATION_FIELD;
        pid_d[adc_pp_pkg::PID_DEV_LSB +: adc_pp_pkg::DEV_W]   = P_DEVICE_CODE;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            pid_q <= adc_pp_pkg::PID_RST;
        end
        else
        begin
            pid_q <= pid_d;
        end
    end

    assign O_PART_IDENT_LOW = pid_q;

    // trims
    trim_port_if trim_port ();

    assign trim_port.we    = I_TRIM_WE;
    assign trim_port.waddr = I_TRIM_WADDR;
    assign trim_port.wdata = I_TRIM_WDATA;
    assign trim_port.raddr = I_TRIM_RADDR;
    assign O_TRIM_RDATA    = trim_port.rdata;

    trim_store u_trim_store
    (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .port   (trim_port.store)
    );

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    for (genvar p = 0; p < NP; p++)
    begin : g_chk
        chk_result_difference: assert property (hit[p] |=> O_PPB_VALID[p] &&
            O_PPB_RESULT[p] == {1'b0, $past(I_RAW_RESULT)} - {1'b0, $past(I_PPB_OFFSET[p])})
            else $error("processed result is not raw minus offset");
        chk_result_negative: assert property (hit[p] && I_RAW_RESULT < I_PPB_OFFSET[p]
            |=> O_PPB_RESULT[p][16])
            else $error("result below reference not negative");
        chk_trip_unsigned: assert property (hit[p] |=> O_PPB_HIGH_TRIP[p] ==
            ($past(I_PPB_HIGH_EN[p]) && O_PPB_RESULT[p][15:0] > $past(I_PPB_HIGH_LIMIT[p])))
            else $error("high trip not the unsigned compare");
        chk_trip_low_idle: assert property (!hit[p] |=> !O_PPB_LOW_TRIP[p] && !O_PPB_VALID[p])
            else $error("low trip without conversion");
        chk_limit_unreliable: assert property (
            (I_PPB_HIGH_EN[p] || I_PPB_LOW_EN[p]) && I_PPB_OFFSET[p] != 16'h0000
            |=> O_PPB_LIMIT_UNRELIABLE[p])
            else $error("unreliable limit flag missing");
    end

    for (genvar n = 0; n < NL; n++)
    begin : g_chk_int
        chk_single_shot_block: assert property (!I_INT_CONT[n] && O_INT_FLAG[n]
            |=> !O_INT_PULSE[n])
            else $error("second interrupt while flag set");
        chk_clear_rearms: assert property (I_INT_FLAG_CLR[n] && !ev[n] ##1
            (ev[n] && !I_INT_CONT[n]) |=> O_INT_PULSE[n] && O_INT_FLAG[n])
            else $error("clear did not re-arm line");
        chk_set_beats_clear: assert property (ev[n] && I_INT_FLAG_CLR[n] |=> O_INT_FLAG[n])
            else $error("event lost to simultaneous clear");
        chk_flag_holds: assert property (
            O_INT_FLAG[n] && !I_INT_FLAG_CLR[n] |=> O_INT_FLAG[n])
            else $error("flag dropped without clear");
    end

    chk_qualification_field_field: assert property (##1 O_PART_IDENT_LOW[7:6] == P_QUALIFICATION_FIELD)
        else $error("qualification field wrong");

    cov_two_blocks_one_slot: cover property (hit[0] && hit[1]);
    cov_zero_cross: cover property (O_PPB_ZERO_CROSS[0]);
    cov_blocked_event: cover property (ev[0] && O_INT_FLAG[0] && !I_INT_CONT[0]);
    cov_continue_mode: cover property (O_INT_PULSE[1] && I_INT_CONT[1] ##1 O_INT_PULSE[1]);
endmodule
`default_nettype wire

// [dv/adc_postproc_interrupt_logic_test.sv]
// self-checking bench for the post-processing, interrupt flag, ident and trim logic
`default_nettype none
module adc_postproc_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    // device code value is arbitrary
    localparam logic [7:0]  DEV_CODE  = 8'hC3;
    localparam logic [31:0] EXP_IDENT = {16'h0000, DEV_CODE, adc_pp_pkg::QUALIFICATION_FIELD_PROTOTYPE, 6'h00};
    localparam int          MAX_CYC   = 20000;

    logic                                      clk;
    logic                                      rstn;
    logic                                      conv_done;
    logic [3:0]                                conv_slot;
    logic [15:0]                               raw;
    logic [adc_pp_pkg::NUM_PPB-1:0][3:0]       ppb_sel;
    logic [adc_pp_pkg::NUM_PPB-1:0][15:0]      ppb_off;
    logic [adc_pp_pkg::NUM_PPB-1:0][15:0]      ppb_hi;
    logic [adc_pp_pkg::NUM_PPB-1:0][15:0]      ppb_lo;
    logic [adc_pp_pkg::NUM_PPB-1:0]            hi_en;
    logic [adc_pp_pkg::NUM_PPB-1:0]            lo_en;
    logic [adc_pp_pkg::NUM_PPB-1:0][16:0]      ppb_res;
    logic [adc_pp_pkg::NUM_PPB-1:0]            ppb_valid;
    logic [adc_pp_pkg::NUM_PPB-1:0]            zero_x;
    logic [adc_pp_pkg::NUM_PPB-1:0]            hi_trip;
    logic [adc_pp_pkg::NUM_PPB-1:0]            lo_trip;
    logic [adc_pp_pkg::NUM_PPB-1:0]            unrel;
    logic [adc_pp_pkg::NUM_LINES-1:0][3:0]     int_sel;
    logic [adc_pp_pkg::NUM_LINES-1:0]          int_cont;
    logic [adc_pp_pkg::NUM_LINES-1:0]          flag_clr;
    logic [adc_pp_pkg::NUM_LINES-1:0]          ovf_clr;
    logic [adc_pp_pkg::NUM_LINES-1:0]          int_flag;
    logic [adc_pp_pkg::NUM_LINES-1:0]          int_ovf;
    logic [adc_pp_pkg::NUM_LINES-1:0]          int_pulse;
    logic [31:0]                               ident;
    logic                                      trim_we;
    logic [3:0]                                trim_waddr;
    logic [15:0]                               trim_wdata;
    logic [3:0]                                trim_raddr;
    logic [15:0]                               trim_rdata;
    int                                        n_errors;
    int                                        n_compared;
    int                                        seed;
    int                                        cycles;
    logic [15:0]                               r;
    logic [16:0]                               e1;
    logic                                      prev_neg;

    adc_pp_top #(.P_QUALIFICATION_FIELD(adc_pp_pkg::QUALIFICATION_FIELD_PROTOTYPE), .P_DEVICE_CODE(DEV_CODE)) i_adc_pp_top
    (
        .I_CLK(clk), .I_RSTN(rstn), .I_CONV_DONE(conv_done), .I_CONV_SLOT(conv_slot),
        .I_RAW_RESULT(raw), .I_PPB_SLOT_SEL(ppb_sel), .I_PPB_OFFSET(ppb_off),
        .I_PPB_HIGH_LIMIT(ppb_hi), .I_PPB_LOW_LIMIT(ppb_lo), .I_PPB_HIGH_EN(hi_en),
        .I_PPB_LOW_EN(lo_en), .O_PPB_RESULT(ppb_res), .O_PPB_VALID(ppb_valid),
        .O_PPB_ZERO_CROSS(zero_x), .O_PPB_HIGH_TRIP(hi_trip), .O_PPB_LOW_TRIP(lo_trip),
        .O_PPB_LIMIT_UNRELIABLE(unrel), .I_INT_SLOT_SEL(int_sel), .I_INT_CONT(int_cont),
        .I_INT_FLAG_CLR(flag_clr), .I_INT_OVF_CLR(ovf_clr), .O_INT_FLAG(int_flag),
        .O_INT_OVF(int_ovf), .O_INT_PULSE(int_pulse), .O_PART_IDENT_LOW(ident),
        .I_TRIM_WE(trim_we), .I_TRIM_WADDR(trim_waddr), .I_TRIM_WDATA(trim_wdata),
        .I_TRIM_RADDR(trim_raddr), .O_TRIM_RDATA(trim_rdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // processed result is the raw value less the reference, two's complement
    function automatic logic [16:0] exp_result(input logic [15:0] rv, input logic [15:0] off);
        return {1'b0, rv} - {1'b0, off};
    endfunction

    task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_vec(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one conversion; outputs are looked at in the cycle after the taking edge
    task automatic conv(input logic [3:0] s, input logic [15:0] rv);
        @(negedge clk);
        conv_done = 1'b1;
        conv_slot = s;
        raw = rv;
        @(negedge clk);
        conv_done = 1'b0;
        raw = ~rv;
    endtask

    task automatic trim_rd(input logic [3:0] a, input logic [15:0] exp);
        @(negedge clk);
        trim_raddr = a;
        @(negedge clk);
        chk_vec("trim read", {16'h0, exp}, {16'h0, trim_rdata});
    endtask

    task automatic trim_wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk);
        trim_we = 1'b1;
        trim_waddr = a;
        trim_wdata = d;
        @(negedge clk);
        trim_we = 1'b0;
        // read back the word just written on the very next edge
        trim_raddr = a;
    endtask

    // a hang is cut short here
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= MAX_CYC)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        {n_errors, n_compared, cycles} = '0;
        seed = 42;
        rstn = 1'b0;
        {conv_done, conv_slot, raw, trim_we, trim_waddr, trim_wdata, trim_raddr} = '0;
        {ppb_off, ppb_hi, ppb_lo, hi_en, lo_en, int_cont, flag_clr, ovf_clr} = '0;
        ppb_sel = {4'h3, 4'h3};
        int_sel = {4'hB, 4'hA, 4'h9, 4'h8};
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk_vec("ident", EXP_IDENT, ident);
        for (int a = 0; a < 11; a++)
            trim_rd(a[3:0], 16'h0000);
        trim_wr(adc_pp_pkg::TRIM_REF_ADDR, 16'h7BDD);
        trim_wr(4'hA, 16'hFFFF);
        trim_rd(adc_pp_pkg::TRIM_REF_ADDR, 16'h7BDD);
        trim_rd(4'hA, 16'h0000);
        trim_wr(adc_pp_pkg::TRIM_OSC_ADDR, 16'h0001);
        trim_rd(adc_pp_pkg::TRIM_OSC_ADDR, 16'h0001);
        trim_wr(adc_pp_pkg::TRIM_OSC_ADDR, 16'h03FF);
        trim_rd(adc_pp_pkg::TRIM_OSC_ADDR, 16'h03FF);
        $display("test trims done");
        // limits on block 0 at zero offset, offset on block 1, both on one slot
        ppb_hi[0] = 16'h4000;
        ppb_lo[0] = 16'h1000;
        {hi_en[0], lo_en[0]} = 2'b11;
        for (int i = 0; i < 12; i++)
        begin
            r = 16'($random(seed));
            ppb_off[1] = 16'h0001 | 16'($random(seed));
            e1 = exp_result(r, ppb_off[1]);
            conv(4'h3, r);
            chk_vec("result 0", {15'h0, exp_result(r, 16'h0)}, {15'h0, ppb_res[0]});
            chk_vec("result 1", {15'h0, e1}, {15'h0, ppb_res[1]});
            chk_vec("valid", 32'h3, {30'h0, ppb_valid});
            chk_bit("high trip", r > 16'h4000, hi_trip[0]);
            chk_bit("low trip", r < 16'h1000, lo_trip[0]);
            chk_bit("zero cross", (i > 0) && (e1[16] != prev_neg), zero_x[1]);
            prev_neg = e1[16];
        end
        conv(4'h5, 16'h1234);
        chk_vec("valid other slot", 32'h0, {30'h0, ppb_valid});
        ppb_off[1] = 16'h1000;
        conv(4'h3, 16'h8000);
        chk_bit("high trip", 1'b1, hi_trip[0]);
        chk_bit("low trip", 1'b0, lo_trip[0]);
        conv(4'h3, 16'h0800);
        chk_bit("low trip", 1'b1, lo_trip[0]);
        chk_bit("zero cross", 1'b1, zero_x[1]);
        chk_vec("negative result", 32'h1F800, {15'h0, ppb_res[1]});
        chk_vec("unreliable", 32'h0, {30'h0, unrel});
        hi_en[1] = 1'b1;
        repeat (2) @(negedge clk);
        chk_vec("unreliable", 32'h2, {30'h0, unrel});
        $display("test post processing done");
        for (int n = 0; n < 4; n++)
        begin
            conv(4'h8 + n[3:0], 16'($random(seed)));
            chk_bit("flag", 1'b1, int_flag[n]);
            chk_bit("pulse", 1'b1, int_pulse[n]);
            conv(4'h8 + n[3:0], 16'h0000);
            chk_bit("pulse blocked", 1'b0, int_pulse[n]);
            chk_bit("overflow", 1'b1, int_ovf[n]);
            @(negedge clk);
            flag_clr[n] = 1'b1;
            ovf_clr[n] = 1'b1;
            @(negedge clk);
            flag_clr[n] = 1'b0;
            ovf_clr[n] = 1'b0;
            chk_bit("flag cleared", 1'b0, int_flag[n]);
            chk_bit("overflow cleared", 1'b0, int_ovf[n]);
            // event on the edge right after the clear, so the re-arm shows at once
            conv_done = 1'b1;
            conv_slot = 4'h8 + n[3:0];
            @(negedge clk);
            conv_done = 1'b0;
            chk_bit("pulse rearmed", 1'b1, int_pulse[n]);
            // clear and event in one cycle: the event wins, no pulse while set
            @(negedge clk);
            flag_clr[n] = 1'b1;
            conv_done = 1'b1;
            @(negedge clk);
            flag_clr[n] = 1'b0;
            conv_done = 1'b0;
            chk_bit("flag set wins", 1'b1, int_flag[n]);
            chk_bit("pulse held", 1'b0, int_pulse[n]);
            chk_bit("overflow", 1'b1, int_ovf[n]);
            int_cont[n] = 1'b1;
            conv(4'h8 + n[3:0], 16'h0000);
            chk_bit("pulse continued", 1'b1, int_pulse[n]);
            chk_vec("other pulses", {28'h0, 4'h1 << n}, {28'h0, int_pulse});
        end
        $display("test interrupts done");
        end_sim();
    end
endmodule
`default_nettype wire
